// File: rtl/emi_consts.vh
// Constants for the external data memory interface
`ifndef EMI_CONSTS_VH
`define EMI_CONSTS_VH

// Register indices and byte addresses (byte address = 4 x index)
`define EMI_IDX_TIMING     8'ha1
`define EMI_IDX_PAGE       8'ha2
`define EMI_IDX_CONFIG     8'ha3
`define EMI_IDX_STATUS     8'ha4
`define EMI_ADDR_TIMING    12'h284
`define EMI_ADDR_PAGE      12'h288
`define EMI_ADDR_CONFIG    12'h28c
`define EMI_ADDR_STATUS    12'h290

// Reset values and config write mask
`define EMI_RST_CONFIG     8'h03
`define EMI_RST_TIMING     8'hff
`define EMI_RST_PAGE       8'h00
`define EMI_CONFIG_MASK    8'h3f

// Configuration fields
`define EMI_CFG_PSEL       5
`define EMI_CFG_NONMUX     4
`define EMI_CFG_MODE_HI    3
`define EMI_CFG_MODE_LO    2
`define EMI_CFG_ALE_HI     1
`define EMI_CFG_ALE_LO     0

// Timing fields
`define EMI_TIM_SETUP_HI   7
`define EMI_TIM_SETUP_LO   6
`define EMI_TIM_STRB_HI    5
`define EMI_TIM_STRB_LO    2
`define EMI_TIM_HOLD_HI    1
`define EMI_TIM_HOLD_LO    0

// Memory map modes
`define EMI_MODE_INTERNAL  2'h0
`define EMI_MODE_SPLIT     2'h1
`define EMI_MODE_BANK      2'h2
`define EMI_MODE_EXTERNAL  2'h3

// On-chip space: 4k, boundary on address bit 12
`define EMI_ONCHIP_AW      12
`define EMI_ONCHIP_WORDS   4096

// Tail counter load; tail lasts two cycles (plus start and done = 4)
`define EMI_TAIL_LOAD      4'h1

// AXI responses
`define EMI_RESP_OKAY      2'h0
`define EMI_RESP_SLVERR    2'h2

`endif

// File: rtl/emi_xram.v
// On-chip data RAM with one-cycle synchronous read
`timescale 1ns/1ps
module emi_xram #(
    parameter AW = 12,
    parameter DW = 8
) (
    input  wire          ref_clk,
    input  wire          rst_n,
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write port; a write leaves rdata unchanged, read returns stored word
    always @(posedge ref_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    // Registered read port
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= {DW{1'b0}};
        end else if (en && !we) begin
            rdata <= mem[addr];
        end
    end
endmodule // emi_xram

// File: rtl/emi_ext_mem_if.v
// External data memory interface: routing, pin sequencing and registers
// Behaviour
// - port select picks lower or upper pin group
// - mux bit: 0 shared pins, 1 separate
// - internal mode: all on-chip, address wraps 4k
// - split modes: below 4k on-chip, else off-chip
// - split no-bank: 8-bit access drives low byte only
// - 8-bit access uses page to decide target
// - bank mode drives page high, index low
// - external mode: all off-chip, high undriven on 8-bit access
// - wide access uses pointer, drives 16 bits
// - muxed: data and low address share pins
// - muxed: address, latch strobe, then data phase
// - non-muxed: separate address and data pins
// - latch strobe high/low width 1 to 4
// - off-chip access costs timing plus five cycles
// - muxed access adds latch strobe high and low time
// - setup and hold reset to longest
// - config resets 03, top bits read zero
// - pins claimed only during off-chip access
// - input pins undriven during read strobe
// - timing register fields, reset value ff
// - page register supplies high address byte
`timescale 1ns/1ps
`include "emi_consts.vh"
module emi_ext_mem_if (
    input  wire        ref_clk,
    input  wire        rst_n,
    // AXI4-Lite register slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Core external move access port
    input  wire        acc_req,
    input  wire        acc_write,
    input  wire        acc_wide,
    input  wire [15:0] data_pointer_reg,
    input  wire [7:0]  acc_index,
    input  wire [7:0]  acc_wdata,
    output wire        acc_ready,
    output reg         acc_done,
    output reg  [7:0]  acc_rdata,
    // Lower port group pins
    output wire [7:0]  lo_addr_hi_out,
    output wire        lo_addr_hi_oe,
    output wire [7:0]  lo_addr_lo_out,
    output wire        lo_addr_lo_oe,
    output wire [7:0]  lo_data_out,
    output wire        lo_data_oe,
    input  wire [7:0]  lo_data_in,
    output wire        lo_rd_n,
    output wire        lo_wr_n,
    output wire        lo_strobe_oe,
    output wire        lo_ale,
    output wire        lo_ale_oe,
    // Upper port group pins
    output wire [7:0]  up_addr_hi_out,
    output wire        up_addr_hi_oe,
    output wire [7:0]  up_addr_lo_out,
    output wire        up_addr_lo_oe,
    output wire [7:0]  up_data_out,
    output wire        up_data_oe,
    input  wire [7:0]  up_data_in,
    output wire        up_rd_n,
    output wire        up_wr_n,
    output wire        up_strobe_oe,
    output wire        up_ale,
    output wire        up_ale_oe
);
    localparam [3:0] S_IDLE   = 4'h0;
    localparam [3:0] S_RAM    = 4'h1;
    localparam [3:0] S_START  = 4'h2;
    localparam [3:0] S_ALEH   = 4'h3;
    localparam [3:0] S_ALEL   = 4'h4;
    localparam [3:0] S_SETUP  = 4'h5;
    localparam [3:0] S_STROBE = 4'h6;
    localparam [3:0] S_HOLD   = 4'h7;
    localparam [3:0] S_TAIL   = 4'h8;
    localparam [3:0] S_DONE   = 4'h9;

    reg  [7:0]  ext_mem_config_reg;
    reg  [7:0]  ext_mem_timing_reg;
    reg  [7:0]  xram_page_reg;
    reg  [3:0]  state;
    reg  [3:0]  cnt;
    reg  [15:0] addr_q;
    reg  [7:0]  wdata_q;
    reg         write_q;
    reg         drive_hi_q;
    reg         mux_q;
    reg         psel_q;
    reg  [1:0]  ale_q;
    reg  [1:0]  setup_q;
    reg  [3:0]  strobe_q;
    reg  [1:0]  hold_q;
    reg         last_offchip;
    reg  [7:0]  sync1;
    reg  [7:0]  sync2;
    reg  [7:0]  sync3;
    reg  [7:0]  data_sync;
    reg         aw_got;
    reg         w_got;
    reg  [11:0] aw_addr_q;
    reg  [7:0]  w_data_q;
    reg         w_lane0_q;
    reg  [31:0] rd_word;
    reg         rd_hit;
    reg         wr_hit;
    reg  [15:0] eff_addr;
    reg         onchip;
    reg         hi_drive;
    reg  [2:0]  rd_pipe;                // Strobe end, delayed to sync depth

    wire [1:0]  map_mode  = ext_mem_config_reg[`EMI_CFG_MODE_HI:
                                               `EMI_CFG_MODE_LO];
    wire        take_req  = acc_req && (state == S_IDLE);
    wire        ram_en    = take_req && onchip;
    wire [7:0]  ram_rdata;

    // Effective address and routing decision
    always @* begin
        eff_addr = acc_wide ? data_pointer_reg : {xram_page_reg, acc_index};
        onchip   = 1'b0;
        hi_drive = 1'b1;
        case (map_mode)
            `EMI_MODE_INTERNAL: onchip = 1'b1;
            `EMI_MODE_SPLIT: begin
                onchip   = (eff_addr[15:`EMI_ONCHIP_AW] == 4'h0);
                hi_drive = acc_wide;
            end
            `EMI_MODE_BANK: begin
                onchip   = (eff_addr[15:`EMI_ONCHIP_AW] == 4'h0);
                hi_drive = 1'b1;
            end
            `EMI_MODE_EXTERNAL: begin
                onchip   = 1'b0;
                hi_drive = acc_wide;
            end
            default: onchip = 1'b1;
        endcase
    end

    emi_xram #(
        .AW (`EMI_ONCHIP_AW),
        .DW (8)
    ) u_xram (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .en      (ram_en),
        .we      (acc_write),
        .addr    (eff_addr[`EMI_ONCHIP_AW-1:0]),
        .wdata   (acc_wdata),
        .rdata   (ram_rdata)
    );

    assign acc_ready = (state == S_IDLE);

    // Access sequencer
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state        <= S_IDLE;
            cnt          <= 4'h0;
            addr_q       <= 16'h0000;
            wdata_q      <= 8'h00;
            write_q      <= 1'b0;
            drive_hi_q   <= 1'b0;
            mux_q        <= 1'b0;
            psel_q       <= 1'b0;
            ale_q        <= 2'h0;
            setup_q      <= 2'h0;
            strobe_q     <= 4'h0;
            hold_q       <= 2'h0;
            last_offchip <= 1'b0;
            acc_done     <= 1'b0;
            acc_rdata    <= 8'h00;
            rd_pipe      <= 3'h0;
        end else begin
            acc_done <= 1'b0;
            // Take read pins once the strobe-end sample reaches sync3
            rd_pipe  <= {rd_pipe[1:0],
                         (state == S_STROBE) && (cnt == 4'h0) && !write_q};
            if (rd_pipe[2]) begin
                acc_rdata <= (sync2 == sync3) ? sync3 : data_sync;
            end
            case (state)
                S_IDLE: if (take_req) begin
                    addr_q     <= eff_addr;
                    wdata_q    <= acc_wdata;
                    write_q    <= acc_write;
                    drive_hi_q <= hi_drive;
                    mux_q      <= ~ext_mem_config_reg[`EMI_CFG_NONMUX];
                    psel_q     <= ext_mem_config_reg[`EMI_CFG_PSEL];
                    ale_q      <= ext_mem_config_reg[`EMI_CFG_ALE_HI:
                                                     `EMI_CFG_ALE_LO];
                    setup_q    <= ext_mem_timing_reg[`EMI_TIM_SETUP_HI:
                                                     `EMI_TIM_SETUP_LO];
                    strobe_q   <= ext_mem_timing_reg[`EMI_TIM_STRB_HI:
                                                     `EMI_TIM_STRB_LO];
                    hold_q     <= ext_mem_timing_reg[`EMI_TIM_HOLD_HI:
                                                     `EMI_TIM_HOLD_LO];
                    last_offchip <= ~onchip;
                    state      <= onchip ? S_RAM : S_START;
                end
                S_RAM: begin
                    acc_done  <= 1'b1;
                    acc_rdata <= write_q ? acc_rdata : ram_rdata;
                    state     <= S_IDLE;
                end
                S_START: begin
                    if (mux_q) begin
                        state <= S_ALEH;
                        cnt   <= {2'b00, ale_q};
                    end else if (setup_q != 2'h0) begin
                        state <= S_SETUP;
                        cnt   <= {2'b00, setup_q - 2'h1};
                    end else begin
                        state <= S_STROBE;
                        cnt   <= strobe_q;
                    end
                end
                S_ALEH: begin
                    if (cnt == 4'h0) begin
                        state <= S_ALEL;
                        cnt   <= {2'b00, ale_q};
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_ALEL: begin
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else if (setup_q != 2'h0) begin
                        state <= S_SETUP;
                        cnt   <= {2'b00, setup_q - 2'h1};
                    end else begin
                        state <= S_STROBE;
                        cnt   <= strobe_q;
                    end
                end
                S_SETUP: begin
                    if (cnt == 4'h0) begin
                        state <= S_STROBE;
                        cnt   <= strobe_q;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_STROBE: begin
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else if (hold_q != 2'h0) begin
                        state <= S_HOLD;
                        cnt   <= {2'b00, hold_q - 2'h1};
                    end else begin
                        state <= S_TAIL;
                        cnt   <= `EMI_TAIL_LOAD;
                    end
                end
                S_HOLD: begin
                    if (cnt == 4'h0) begin
                        state <= S_TAIL;
                        cnt   <= `EMI_TAIL_LOAD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_TAIL: begin
                    if (cnt == 4'h0) begin
                        state <= S_DONE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_DONE: begin
                    acc_done <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Read data pin synchroniser
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1     <= 8'h00;
            sync2     <= 8'h00;
            sync3     <= 8'h00;
            data_sync <= 8'h00;
        end else begin
            sync1 <= psel_q ? up_data_in : lo_data_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                data_sync <= sync3;
            end
        end
    end

    // Pin bundle before group routing
    // pins only offchip
    wire       own      = (state != S_IDLE) && (state != S_RAM);
    wire       adr_ph   = (state == S_START) || (state == S_ALEH) ||
                          (state == S_ALEL);
    wire [7:0] p_ahi    = addr_q[15:8];
    wire       p_ahi_oe = own && drive_hi_q;
    wire       p_alo_oe = own && !mux_q;
    wire [7:0] p_dat    = (mux_q && adr_ph) ? addr_q[7:0] : wdata_q;
    wire       p_dat_oe = own && ((mux_q && adr_ph) || write_q);
    wire       p_rd_n   = !((state == S_STROBE) && !write_q);
    wire       p_wr_n   = !((state == S_STROBE) && write_q);
    wire       p_ale    = (state == S_ALEH);
    wire       p_ale_oe = own && mux_q;

    assign lo_addr_hi_out = p_ahi;
    assign lo_addr_hi_oe  = p_ahi_oe && !psel_q;
    assign lo_addr_lo_out = addr_q[7:0];
    assign lo_addr_lo_oe  = p_alo_oe && !psel_q;
    assign lo_data_out    = p_dat;
    assign lo_data_oe     = p_dat_oe && !psel_q;
    assign lo_rd_n        = p_rd_n || psel_q;
    assign lo_wr_n        = p_wr_n || psel_q;
    assign lo_strobe_oe   = own && !psel_q;
    assign lo_ale         = p_ale && !psel_q;
    assign lo_ale_oe      = p_ale_oe && !psel_q;
    assign up_addr_hi_out = p_ahi;
    assign up_addr_hi_oe  = p_ahi_oe && psel_q;
    assign up_addr_lo_out = addr_q[7:0];
    assign up_addr_lo_oe  = p_alo_oe && psel_q;
    assign up_data_out    = p_dat;
    assign up_data_oe     = p_dat_oe && psel_q;
    assign up_rd_n        = p_rd_n || !psel_q;
    assign up_wr_n        = p_wr_n || !psel_q;
    assign up_strobe_oe   = own && psel_q;
    assign up_ale         = p_ale && psel_q;
    assign up_ale_oe      = p_ale_oe && psel_q;

    // AXI write channel and read address acceptance
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Write address decode
    always @* begin
        wr_hit = (aw_addr_q == `EMI_ADDR_CONFIG) ||
                 (aw_addr_q == `EMI_ADDR_TIMING) ||
                 (aw_addr_q == `EMI_ADDR_PAGE);
    end

    // Register writes and write response
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            aw_addr_q    <= 12'h000;
            w_data_q     <= 8'h00;
            w_lane0_q    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EMI_RESP_OKAY;
            ext_mem_config_reg <= `EMI_RST_CONFIG;
            ext_mem_timing_reg <= `EMI_RST_TIMING;
            xram_page_reg      <= `EMI_RST_PAGE;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got    <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got     <= 1'b1;
                w_data_q  <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `EMI_RESP_OKAY : `EMI_RESP_SLVERR;
                if (w_lane0_q) begin
                    if (aw_addr_q == `EMI_ADDR_CONFIG) begin
                        ext_mem_config_reg <= w_data_q & `EMI_CONFIG_MASK;
                    end
                    if (aw_addr_q == `EMI_ADDR_TIMING) begin
                        ext_mem_timing_reg <= w_data_q;
                    end
                    if (aw_addr_q == `EMI_ADDR_PAGE) begin
                        xram_page_reg <= w_data_q;
                    end
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read address decode
    always @* begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        case ({s_axi_araddr[11:2], 2'b00})
            `EMI_ADDR_CONFIG: rd_word = {24'h000000, ext_mem_config_reg};
            `EMI_ADDR_TIMING: rd_word = {24'h000000, ext_mem_timing_reg};
            `EMI_ADDR_PAGE:   rd_word = {24'h000000, xram_page_reg};
            `EMI_ADDR_STATUS: rd_word = {30'h0, last_offchip,
                                         ~acc_ready};
            default:          rd_hit  = 1'b0;
        endcase
    end

    // Read response
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `EMI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `EMI_RESP_OKAY : `EMI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // emi_ext_mem_if

// File: sim/emi_ext_mem_if_properties.sv
// Port assertions for the external memory interface
`timescale 1ns/1ps
module emi_chk (
    input logic ref_clk,
    input logic rst_n,
    input logic acc_done,
    input logic lo_rd_n,
    input logic lo_wr_n,
    input logic lo_strobe_oe,
    input logic lo_ale,
    input logic lo_ale_oe,
    input logic lo_data_oe,
    input logic up_strobe_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_NO_OVERLAP:
    assert property (lo_rd_n || lo_wr_n)
        else $error("both strobes low");
    AST_ONE_GROUP:
    assert property (!(lo_strobe_oe && up_strobe_oe))
        else $error("both pin groups claimed");
    AST_IDLE_PINS:
    assert property (!lo_strobe_oe |-> lo_rd_n && lo_wr_n)
        else $error("strobe low while pins released");
    AST_ADDR_PHASE:
    assert property ($rose(lo_ale) |-> lo_data_oe && lo_ale_oe && lo_rd_n)
        else $error("latch strobe without address phase");
    AST_ALE_LOW:
    assert property ($fell(lo_ale) |-> lo_rd_n && lo_wr_n)
        else $error("strobe during latch low time");
    AST_MIN_LEN:
    assert property ($rose(lo_strobe_oe) |-> lo_strobe_oe [*5])
        else $error("off-chip access too short");
    AST_END_DONE:
    assert property ($fell(lo_strobe_oe) |-> acc_done)
        else $error("pins released without completion");
    AST_READ_HIZ:
    assert property (!lo_rd_n |-> !lo_data_oe)
        else $error("data driven during read");
    cover property ($rose(lo_ale));
    cover property ($fell(lo_wr_n));
    cover property ($fell(lo_rd_n) && !lo_ale_oe);
endmodule // emi_chk

// File: sim/emi_sram_model.sv
// Behavioural external SRAM with address latch on one pin group
`timescale 1ns/1ps
module emi_sram_model (
    input  logic       ref_clk,
    input  logic [7:0] hi,
    input  logic       hi_oe,
    input  logic [7:0] lo,
    input  logic [7:0] dout,
    input  logic       rd_n,
    input  logic       wr_n,
    input  logic       ale,
    input  logic       ale_oe,
    output logic [7:0] din
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lat;
    logic [7:0]  rdq;
    logic [7:0]  last = 8'h00;
    logic        hold_q = 1'b0;
    logic [15:0] a;
    // latch passes while strobe high, holds after
    always @* if (ale) lat = dout;
    // undriven high pins rest at the parked port level
    assign a = {hi_oe ? hi : 8'hff, ale_oe ? lat : lo};
    // Write during strobe; read data held one cycle after it
    always @(posedge ref_clk) begin
        if (!wr_n) mem[a] <= dout;
        if (!rd_n) rdq <= mem[a];
        hold_q <= !rd_n;
        if (!rd_n || hold_q) last <= din;
    end
    // Released bus shows the inverse of its last driven value
    assign din = !rd_n ? mem[a] : (hold_q ? rdq : ~last);
endmodule // emi_sram_model

// File: sim/emi_ext_mem_if_tb_top.sv
// Self-checking bench for the external memory interface
`timescale 1ns/1ps
`include "emi_consts.vh"
module emi_ext_mem_if_tb_top;
    logic        ref_clk = 0, rst_n = 0, acc_req = 0, acc_write = 0;
    logic        acc_wide = 0, acc_ready, acc_done, s_axi_bvalid;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [15:0] data_pointer_reg = '0;
    logic [7:0]  acc_index = '0, acc_wdata = '0, acc_rdata;
    logic [7:0]  lo_addr_hi_out, lo_addr_lo_out, lo_data_out, lo_data_in;
    logic [7:0]  up_addr_hi_out, up_addr_lo_out, up_data_out, up_data_in;
    logic        lo_addr_hi_oe, lo_addr_lo_oe, lo_data_oe, lo_rd_n, lo_wr_n;
    logic        lo_strobe_oe, lo_ale, lo_ale_oe, up_addr_hi_oe, up_ale;
    logic        up_addr_lo_oe, up_data_oe, up_rd_n, up_wr_n, up_strobe_oe;
    logic        up_ale_oe;
    int          fails = 0, check_count = 0;

    emi_ext_mem_if dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_req, .acc_write,
        .acc_wide, .data_pointer_reg, .acc_index, .acc_wdata, .acc_ready,
        .acc_done, .acc_rdata, .lo_addr_hi_out, .lo_addr_hi_oe,
        .lo_addr_lo_out, .lo_addr_lo_oe, .lo_data_out, .lo_data_oe,
        .lo_data_in, .lo_rd_n, .lo_wr_n, .lo_strobe_oe, .lo_ale, .lo_ale_oe,
        .up_addr_hi_out, .up_addr_hi_oe, .up_addr_lo_out, .up_addr_lo_oe,
        .up_data_out, .up_data_oe, .up_data_in, .up_rd_n, .up_wr_n,
        .up_strobe_oe, .up_ale, .up_ale_oe);
    emi_sram_model lo_m (.ref_clk, .hi(lo_addr_hi_out), .hi_oe(lo_addr_hi_oe),
        .lo(lo_addr_lo_out), .dout(lo_data_out), .rd_n(lo_rd_n),
        .wr_n(lo_wr_n), .ale(lo_ale), .ale_oe(lo_ale_oe), .din(lo_data_in));
    emi_sram_model up_m (.ref_clk, .hi(up_addr_hi_out), .hi_oe(up_addr_hi_oe),
        .lo(up_addr_lo_out), .dout(up_data_out), .rd_n(up_rd_n),
        .wr_n(up_wr_n), .ale(up_ale), .ale_oe(up_ale_oe), .din(up_data_in));

    // Clock and watchdog
    always #5 ref_clk = ~ref_clk;
    initial begin
        #100000;
        fails++;
        finish_test;
    end

    task chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task axw(input logic [11:0] a, input logic [7:0] d,
             output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        fork
            begin
                @(posedge ref_clk iff s_axi_awready);
                s_axi_awvalid <= 0;
            end
            begin
                @(posedge ref_clk iff s_axi_wready);
                s_axi_wvalid <= 0;
            end
        join
        @(posedge ref_clk iff s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task axr(input logic [11:0] a, output logic [31:0] v,
             output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        @(posedge ref_clk iff s_axi_arready);
        s_axi_arvalid <= 0;
        @(posedge ref_clk iff s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // One core access; n counts edges from take to completion
    task acc(input logic w, wd, input logic [15:0] p,
             input logic [7:0] i, d, output int n);
        @(posedge ref_clk);
        acc_req <= 1;
        acc_write <= w;
        acc_wide <= wd;
        data_pointer_reg <= p;
        acc_index <= i;
        acc_wdata <= d;
        @(posedge ref_clk);
        acc_req <= 0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (acc_done !== 1'b1 && n < 99);
    endtask

    function int lat(input logic [7:0] t, c, input bit on);
        if (on) return 1;
        return t[7:6] + t[5:2] + t[1:0] + 5 + (c[4] ? 0 : 2 * (c[1:0] + 1));
    endfunction

    function logic [7:0] mem_of(input bit u, input logic [15:0] a);
        return u ? up_m.mem[a] : lo_m.mem[a];
    endfunction

    // Main sequence
    initial begin
        logic [7:0] cfg, tm, pg, d, idx;
        logic [15:0] p;
        logic [31:0] v;
        logic [1:0] r, m;
        int n;
        bit on;
        void'($urandom(82));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1;
        axr(`EMI_ADDR_CONFIG, v, r);
        chk("config", v, 32'h03);
        axr(`EMI_ADDR_TIMING, v, r);
        chk("timing", v, 32'hff);
        axr(`EMI_ADDR_PAGE, v, r);
        chk("page", v, 32'h00);
        axw(`EMI_ADDR_CONFIG, 8'hff, r);
        axr(`EMI_ADDR_CONFIG, v, r);
        chk("config top", v, 32'h3f);
        axw(12'h300, 8'h55, r);
        chk("unmapped", r, `EMI_RESP_SLVERR);
        acc(1, 1, 16'hbeef, 8'h00, 8'h5a, n);
        chk("slow lat", n, lat(8'hff, 8'h3f, 0));
        chk("slow mem", up_m.mem[16'hbeef], 8'h5a);
        for (int k = 0; k < 16; k++) begin
            m = 2'(k);
            cfg = {2'b00, 2'($urandom), m, 2'($urandom)};
            tm = 8'($urandom) & 8'hcf;
            pg = 8'($urandom) & (k[2] ? 8'h0f : 8'hff);
            idx = 8'($urandom);
            d = 8'($urandom);
            axw(`EMI_ADDR_CONFIG, cfg, r);
            axw(`EMI_ADDR_TIMING, tm, r);
            axw(`EMI_ADDR_PAGE, pg, r);
            on = m == 0 || (m != 3 && pg < 8'h10);
            acc(1, 0, 16'h0, idx, d, n);
            chk("lat8", n, lat(tm, cfg, on));
            p = {(m == 2 ? pg : 8'hff), idx};
            if (!on) chk("ext8", mem_of(cfg[5], p), d);
            acc(0, 0, 16'h0, idx, 8'h00, n);
            chk("rd8", acc_rdata, d);
            p = 16'($urandom) & (k[3] ? 16'h0fff : 16'hffff);
            d = 8'($urandom);
            on = m == 0 || (m != 3 && p < 16'h1000);
            acc(1, 1, p, 8'h00, d, n);
            chk("lat16", n, lat(tm, cfg, on));
            if (!on) chk("ext16", mem_of(cfg[5], p), d);
            acc(0, 1, m == 0 ? p ^ 16'h1000 : p, 8'h00, 8'h00, n);
            chk("rd16", acc_rdata, d);
        end
        finish_test;
    end
endmodule // emi_ext_mem_if_tb_top

bind emi_ext_mem_if emi_chk chk_i (.ref_clk, .rst_n, .acc_done, .lo_rd_n,
    .lo_wr_n, .lo_strobe_oe, .lo_ale, .lo_ale_oe, .lo_data_oe,
    .up_strobe_oe);
